// file: hw/autr_pkg.sv
/*
 * Constants, register map and mode type of the auxiliary up/down reload timer.
 * Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
 */
package autr_pkg;

	// ----------------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADDR_SPEED = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;
	localparam logic [7:0] ADDR_RELOAD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_MASK = 8'h18;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int SPD_DOUBLE = 0;
	localparam int CTL_CPRL = 0;
	localparam int CTL_CT = 1;
	localparam int CTL_RUN = 2;
	localparam int CTL_TRANSMIT_CLOCK_SELECT = 4;
	localparam int CTL_RCLK = 5;
	localparam int CTL_EXF = 6;
	localparam int CTL_OVF = 7;
	localparam int MOD_DOWN_COUNT_ENABLE = 0;
	localparam int MOD_OUTEN = 1;
	localparam int STS_OVF = 0;

	// ----------------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [3:0] DIV_STANDARD = 4'hC;
	localparam logic [3:0] DIV_DOUBLE = 4'h6;
	localparam logic [3:0] DIV_ONE = 4'h1;
	localparam logic [3:0] PS_RST = 4'h0;

	typedef enum logic [1:0] {
		MODE_CAPTURE,
		MODE_RELOAD,
		MODE_BAUD
	} autr_mode_t;

endpackage

// file: hw/autr_timer.sv
/*
 * Auxiliary 16-bit timer/counter with up/down auto-reload, clock output,
 * baud tick, speed doubling and an APB register slave with interrupt.
 * Assumes the count and direction pins are already synchronous to sys_clk_i.
 */
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// - A speed bit picks 12 or 6 system clocks per time-base step.
// - Reset leaves the speed bit clear; software sets it for double speed.
// - With double speed the timer time base runs twice as fast.
// - The count is sixteen bits, low byte carrying into high byte.
// - A select bit picks the divided clock or the external count pin.
// - The count advances only while the run bit is set.
// - Receive clock, transmit clock and capture/reload bits pick the mode.
// - Reload mode with down count disabled counts up regardless of pin.
// - Reload mode with down count enabled follows the direction pin.
// - Passing FFFFh upward outside baud mode sets the overflow flag, which raises the interrupt while unmasked.
// - An upward overflow loads the reload value into the count, or zero in capture mode.
// - Counting down, reaching the reload value is an underflow that sets the flag.
// - An underflow loads FFFFh into the count.
// - The toggle flag inverts on every overflow or underflow in reload mode with down count enabled, and never interrupts.
// - Baud tick and clock output share the single reload value.
module autr_timer (
	input wire logic sys_clk_i, // System clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic psel_i, // APB select.
	input wire logic penable_i, // APB enable.
	input wire logic pwrite_i, // APB write.
	input wire logic [7:0] paddr_i, // APB byte address.
	input wire logic [31:0] pwdata_i, // APB write data.
	output logic [31:0] prdata_o, // APB read data.
	output logic pready_o, // APB ready.
	output logic pslverr_o, // APB error on unmapped address.
	input wire logic ext_count_pin_i, // External count pin.
	input wire logic count_direction_pin_i, // Direction pin, high counts up.
	output logic irq_o, // Interrupt, level.
	output logic clk_out_o, // Programmable clock output.
	output logic baud_tick_o, // Baud rate tick pulse.
	output logic ext_toggle_o // Toggle flag, seventeenth count bit in reload mode with down count enabled.
);

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	logic double_speed_select_q;
	logic [7:0] aux_timer_control_q;
	logic [1:0] aux_timer_mode_q;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] reload_q;
	logic ovf_flag_q;
	logic ovf_flag_d;
	logic ext_flag_q;
	logic ext_flag_d;
	logic irq_mask_q;
	logic [3:0] ps_q;
	logic [3:0] ps_d;
	logic pin_prev_q;

	// ----------------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------------
	wire access_w = psel_i & penable_i;
	wire done_w = access_w & pready_o;
	wire wr_w = done_w & pwrite_i;
	wire hit_speed_w = paddr_i == autr_pkg::ADDR_SPEED;
	wire hit_ctrl_w = paddr_i == autr_pkg::ADDR_CTRL;
	wire hit_mode_w = paddr_i == autr_pkg::ADDR_MODE;
	wire hit_count_w = paddr_i == autr_pkg::ADDR_COUNT;
	wire hit_reload_w = paddr_i == autr_pkg::ADDR_RELOAD;
	wire hit_status_w = paddr_i == autr_pkg::ADDR_STATUS;
	wire hit_mask_w = paddr_i == autr_pkg::ADDR_MASK;
	wire mapped_w = hit_speed_w | hit_ctrl_w | hit_mode_w | hit_count_w |
		hit_reload_w | hit_status_w | hit_mask_w;
	wire wr_speed_w = wr_w & hit_speed_w;
	wire wr_ctrl_w = wr_w & hit_ctrl_w;
	wire wr_mode_w = wr_w & hit_mode_w;
	wire wr_count_w = wr_w & hit_count_w;
	wire wr_reload_w = wr_w & hit_reload_w;
	wire wr_status_w = wr_w & hit_status_w;
	wire wr_mask_w = wr_w & hit_mask_w;

	wire [7:0] ctrl_view_w = {ovf_flag_q, ext_flag_q, aux_timer_control_q[5:0]};
	wire [31:0] rdata_w =
		hit_speed_w ? {31'h0000_0000, double_speed_select_q} :
		hit_ctrl_w ? {24'h00_0000, ctrl_view_w} :
		hit_mode_w ? {30'h0000_0000, aux_timer_mode_q} :
		hit_count_w ? {16'h0000, count_q} :
		hit_reload_w ? {16'h0000, reload_q} :
		hit_status_w ? {31'h0000_0000, ovf_flag_q} :
		hit_mask_w ? {31'h0000_0000, irq_mask_q} :
		autr_pkg::RDATA_ZERO;

	// One wait state: ready rises in the second access cycle and drops after.
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_o <= 1'b0;
			prdata_o <= autr_pkg::RDATA_ZERO;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= access_w & ~pready_o;
			prdata_o <= (access_w & ~pready_o & ~pwrite_i) ? rdata_w : prdata_o;
			pslverr_o <= access_w & ~pready_o & ~mapped_w;
		end
	end

	// ----------------------------------------------------------------------
	// Configuration
	// ----------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			double_speed_select_q <= 1'b0;
			aux_timer_control_q <= autr_pkg::CTRL_RST;
			aux_timer_mode_q <= autr_pkg::MODE_RST;
			reload_q <= autr_pkg::COUNT_RST;
			irq_mask_q <= 1'b0;
		end else begin
			if (wr_speed_w) begin
				double_speed_select_q <= pwdata_i[autr_pkg::SPD_DOUBLE];
			end
			if (wr_ctrl_w) begin
				aux_timer_control_q <= pwdata_i[7:0];
			end
			if (wr_mode_w) begin
				aux_timer_mode_q <= pwdata_i[1:0];
			end
			if (wr_reload_w) begin
				reload_q <= pwdata_i[15:0];
			end
			if (wr_mask_w) begin
				irq_mask_q <= pwdata_i[autr_pkg::STS_OVF];
			end
		end
	end

	wire cprl_w = aux_timer_control_q[autr_pkg::CTL_CPRL];
	wire ctsel_w = aux_timer_control_q[autr_pkg::CTL_CT];
	wire run_w = aux_timer_control_q[autr_pkg::CTL_RUN];
	wire transmit_clock_select_w = aux_timer_control_q[autr_pkg::CTL_TRANSMIT_CLOCK_SELECT];
	wire rclk_w = aux_timer_control_q[autr_pkg::CTL_RCLK];
	wire down_count_enable_w = aux_timer_mode_q[autr_pkg::MOD_DOWN_COUNT_ENABLE];
	wire outen_w = aux_timer_mode_q[autr_pkg::MOD_OUTEN];

	// Either serial clock select overrides the capture/reload choice.
	autr_pkg::autr_mode_t mode_w;
	assign mode_w = (rclk_w | transmit_clock_select_w) ? autr_pkg::MODE_BAUD :
		cprl_w ? autr_pkg::MODE_CAPTURE : autr_pkg::MODE_RELOAD;
	wire is_reload_w = mode_w == autr_pkg::MODE_RELOAD;
	wire is_baud_w = mode_w == autr_pkg::MODE_BAUD;
	wire is_capture_w = mode_w == autr_pkg::MODE_CAPTURE;

	// ----------------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------------
	// The limit is compared with >= so a speed change mid-period cannot
	// leave the prescaler past its wrap point.
	wire [3:0] ps_div_w = double_speed_select_q ? autr_pkg::DIV_DOUBLE :
		autr_pkg::DIV_STANDARD;
	wire [3:0] ps_last_w = ps_div_w - autr_pkg::DIV_ONE;
	wire ps_wrap_w = ps_q >= ps_last_w;
	assign ps_d = ps_wrap_w ? autr_pkg::PS_RST : ps_q + autr_pkg::DIV_ONE;

	// Pin levels shorter than one clock are missed by this edge detector.
	wire pin_fall_w = pin_prev_q & ~ext_count_pin_i;
	wire tick_w = ctsel_w ? pin_fall_w : ps_wrap_w;
	wire adv_w = tick_w & run_w;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ps_q <= autr_pkg::PS_RST;
			pin_prev_q <= 1'b0;
		end else begin
			ps_q <= ps_d;
			pin_prev_q <= ext_count_pin_i;
		end
	end

	// ----------------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------------
	wire down_w = is_reload_w & down_count_enable_w & ~count_direction_pin_i;
	wire at_max_w = count_q == autr_pkg::COUNT_MAX;
	wire at_reload_w = count_q == reload_q;
	wire evt_up_w = adv_w & ~down_w & at_max_w;
	wire evt_dn_w = adv_w & down_w & at_reload_w;
	wire evt_w = evt_up_w | evt_dn_w;
	wire [15:0] up_val_w = is_capture_w ? autr_pkg::COUNT_RST : reload_q;
	wire [15:0] step_w = down_w ? count_q - autr_pkg::COUNT_ONE :
		count_q + autr_pkg::COUNT_ONE;

	// A software write to the count wins over a step in the same cycle.
	assign count_d = wr_count_w ? pwdata_i[15:0] :
		evt_up_w ? up_val_w :
		evt_dn_w ? autr_pkg::COUNT_MAX :
		adv_w ? step_w : count_q;

	// ----------------------------------------------------------------------
	// Flags and outputs
	// ----------------------------------------------------------------------
	wire ovf_set_w = evt_w & ~is_baud_w;
	wire ovf_clr_w = wr_status_w & pwdata_i[autr_pkg::STS_OVF];
	assign ovf_flag_d = ovf_set_w | (ovf_flag_q & ~ovf_clr_w);
	wire tog_w = evt_w & is_reload_w & down_count_enable_w;
	wire ext_base_w = wr_ctrl_w ? pwdata_i[autr_pkg::CTL_EXF] : ext_flag_q;
	assign ext_flag_d = ext_base_w ^ tog_w;
	// The interrupt follows the mask as it will stand after this edge, so a
	// mask write never leaves the output one cycle behind the mask register.
	wire irq_mask_d_w = wr_mask_w ? pwdata_i[autr_pkg::STS_OVF] : irq_mask_q;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_q <= autr_pkg::COUNT_RST;
			ovf_flag_q <= 1'b0;
			ext_flag_q <= 1'b0;
			irq_o <= 1'b0;
			clk_out_o <= 1'b0;
			baud_tick_o <= 1'b0;
			ext_toggle_o <= 1'b0;
		end else begin
			count_q <= count_d;
			ovf_flag_q <= ovf_flag_d;
			ext_flag_q <= ext_flag_d;
			irq_o <= ovf_flag_d & irq_mask_d_w;
			clk_out_o <= clk_out_o ^ (evt_w & outen_w);
			baud_tick_o <= evt_w & is_baud_w;
			ext_toggle_o <= ext_flag_d;
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_up_wrap;
		adv_w && !down_w && at_max_w && is_reload_w && !wr_count_w;
	endsequence

	sequence s_down_hit;
		adv_w && down_w && at_reload_w && !wr_count_w;
	endsequence

	sequence s_capture_wrap;
		adv_w && !down_w && at_max_w && is_capture_w && !wr_count_w;
	endsequence

	sequence s_baud_wrap;
		adv_w && at_max_w && is_baud_w && !wr_count_w;
	endsequence

	// ----------------------------------------------------------------------
	// Counter checks
	// ----------------------------------------------------------------------
	a_up_reload: assert property (s_up_wrap |=> count_q == $past(reload_q))
		else $error("Up overflow did not load reload value.");

	a_down_all_ones: assert property (s_down_hit |=> count_q == autr_pkg::COUNT_MAX)
		else $error("Underflow did not load all ones.");

	a_capture_zero: assert property (s_capture_wrap |=> count_q == autr_pkg::COUNT_RST)
		else $error("Capture mode overflow did not wrap to zero.");

	a_baud_reload: assert property (s_baud_wrap |=> count_q == $past(reload_q))
		else $error("Baud mode overflow did not load reload value.");

	a_run_hold: assert property (!run_w && !wr_count_w |=> $stable(count_q))
		else $error("Count moved while stopped.");

	// A count may only move on a step of the selected source.
	a_timer_source: assert property (!ctsel_w && !ps_wrap_w && !wr_count_w |=>
		$stable(count_q))
		else $error("Timer count moved without a time base step.");

	a_pin_source: assert property (ctsel_w && !pin_fall_w && !wr_count_w |=>
		$stable(count_q))
		else $error("Counter count moved without a pin fall.");

	a_byte_carry: assert property (adv_w && !down_w && !at_max_w && (&count_q[7:0]) &&
		!wr_count_w |=> count_q[15:8] == $past(count_q[15:8]) + autr_pkg::COUNT_ONE[7:0])
		else $error("Low byte did not carry into high byte.");

	a_dir_down: assert property (adv_w && is_reload_w && down_count_enable_w && !count_direction_pin_i &&
		!at_reload_w && !wr_count_w |=> count_q == $past(count_q) - autr_pkg::COUNT_ONE)
		else $error("Down count step wrong.");

	a_dir_up: assert property (adv_w && is_reload_w && down_count_enable_w && count_direction_pin_i &&
		!at_max_w && !wr_count_w |=> count_q == $past(count_q) + autr_pkg::COUNT_ONE)
		else $error("Up count step with direction pin wrong.");

	a_up_fixed: assert property (adv_w && is_reload_w && !down_count_enable_w && !at_max_w &&
		!wr_count_w |=> count_q == $past(count_q) + autr_pkg::COUNT_ONE)
		else $error("Up count step wrong.");

	// ----------------------------------------------------------------------
	// Time base checks
	// ----------------------------------------------------------------------
	// A span only counts when the speed bit stayed put through all of it, so
	// a speed change in mid-period is left out rather than excused at the end.
	sequence s_standard_span;
		!double_speed_select_q && ps_q == autr_pkg::PS_RST ##1
			!double_speed_select_q [*8] ##1 !double_speed_select_q [*3];
	endsequence

	sequence s_double_span;
		double_speed_select_q && ps_q == autr_pkg::PS_RST ##1 double_speed_select_q [*5];
	endsequence

	a_standard_period: assert property (s_standard_span |-> ps_wrap_w)
		else $error("Standard time base period wrong.");

	a_double_period: assert property (s_double_span |-> ps_wrap_w)
		else $error("Double speed time base period wrong.");

	a_speed_hold: assert property (!wr_speed_w |=> $stable(double_speed_select_q))
		else $error("Speed bit changed without a write.");

	// ----------------------------------------------------------------------
	// Flag and output checks
	// ----------------------------------------------------------------------
	a_flag_on_event: assert property ((s_up_wrap or s_down_hit) |=> ovf_flag_q)
		else $error("Overflow flag not set on event.");

	a_flag_sticky: assert property (ovf_flag_q && !ovf_clr_w |=> ovf_flag_q)
		else $error("Overflow flag cleared without software.");

	a_flag_clear: assert property (ovf_clr_w && !ovf_set_w |=> !ovf_flag_q)
		else $error("Overflow flag survived a software clear.");

	a_baud_no_flag: assert property (evt_w && is_baud_w && !ovf_flag_q |=> !ovf_flag_q)
		else $error("Baud mode overflow set the overflow flag.");

	a_toggle_bit: assert property (tog_w && !wr_ctrl_w |=> ext_flag_q != $past(ext_flag_q))
		else $error("Toggle flag did not invert.");

	a_toggle_hold: assert property (!tog_w && !wr_ctrl_w |=> $stable(ext_flag_q))
		else $error("Toggle flag moved without an event.");

	// The toggle flag has no path to the interrupt: only the overflow flag does.
	a_toggle_quiet: assert property (!ovf_flag_q |-> !irq_o)
		else $error("Interrupt raised without the overflow flag.");

	a_irq_masked: assert property (!irq_mask_q |-> !irq_o)
		else $error("Interrupt raised while masked.");

	a_irq_level: assert property (ovf_flag_q && irq_mask_q |-> irq_o)
		else $error("Interrupt not raised for unmasked flag.");

	a_baud_pulse: assert property (evt_w && is_baud_w |=> baud_tick_o)
		else $error("Baud tick missing after overflow.");

	a_baud_quiet: assert property (!(evt_w && is_baud_w) |=> !baud_tick_o)
		else $error("Baud tick without a baud overflow.");

	a_clk_toggle: assert property (evt_w && outen_w |=> clk_out_o != $past(clk_out_o))
		else $error("Clock output did not toggle on event.");

	a_clk_hold: assert property (!(evt_w && outen_w) |=> $stable(clk_out_o))
		else $error("Clock output moved without an event.");

endmodule // autr_timer

// file: verif/autr_pin_model.sv
/*
 * Model of the external count and direction pins that feed the auxiliary timer.
 * Assumes the timer samples both pins on sys_clk_i and counts a falling count pin.
 */
`timescale 1ns/10ps
module autr_pin_model (
	input wire logic sys_clk_i, // System clock.
	output logic count_pin_o, // Count pin, idles high.
	output logic dir_pin_o // Direction pin, high counts up.
);
	initial begin
		count_pin_o = 1'b1;
		dir_pin_o = 1'b0;
	end

	// Each level is held at least two clocks, so a fall is never missed or counted twice.
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge sys_clk_i) count_pin_o <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
			count_pin_o <= 1'b1;
			repeat (2) @(posedge sys_clk_i);
		end
	endtask

	task automatic set_dir(input logic d);
		@(posedge sys_clk_i) dir_pin_o <= d;
	endtask
endmodule // autr_pin_model

// file: verif/aux_timer_updown_reload_tb.sv
/*
 * Self-checking bench of the auxiliary up/down reload timer over APB.
 * Assumes the pin model drives the count and direction pins synchronously.
 */
`timescale 1ns/10ps
module aux_timer_updown_reload_tb;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, baud_tick, tgl;
	logic cnt_pin, dir_pin, cko;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int bad_count, checked, ticks;

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	autr_timer i_dut (
		.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .ext_count_pin_i(cnt_pin),
		.count_direction_pin_i(dir_pin), .irq_o(irq), .clk_out_o(cko),
		.baud_tick_o(baud_tick), .ext_toggle_o(tgl)
	);
	autr_pin_model i_pins (.sys_clk_i(sys_clk), .count_pin_o(cnt_pin), .dir_pin_o(dir_pin));

	always @(posedge sys_clk) if (baud_tick === 1'b1) ticks++;

	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic results();
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 20) begin
				bad_count++;
				results();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, {16'h0000, d}, rd, e);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0000_0000, rd, e);
		chk(rd, {16'h0000, exp});
	endtask

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] rd;
		logic e;
		rdchk(autr_pkg::ADDR_SPEED, 16'h0000);
		rdchk(autr_pkg::ADDR_CTRL, 16'h0000);
		rdchk(autr_pkg::ADDR_COUNT, 16'h0000);
		apb(1'b0, 8'h1C, 32'h0000_0000, rd, e);
		chk({31'h0, e}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
	endtask

	// The step phase is unknown, so one extra step is allowed.
	task automatic t_rate(input logic x2, input logic [15:0] exp);
		logic [31:0] rd;
		logic [15:0] d;
		logic e;
		wr(autr_pkg::ADDR_SPEED, {15'h0000, x2});
		wr(autr_pkg::ADDR_COUNT, 16'h0000);
		wr(autr_pkg::ADDR_CTRL, 16'h0004);
		repeat (240) @(posedge sys_clk);
		wr(autr_pkg::ADDR_CTRL, 16'h0000);
		apb(1'b0, autr_pkg::ADDR_COUNT, 32'h0000_0000, rd, e);
		d = rd[15:0] - exp;
		chk({31'h0, (d === 16'h0000) || (d === 16'h0001)}, 32'h0000_0001);
		repeat (30) @(posedge sys_clk);
		rdchk(autr_pkg::ADDR_COUNT, rd[15:0]);
	endtask

	task automatic t_modes();
		logic [15:0] ctl[4] = '{16'h0006, 16'h0007, 16'h0026, 16'h0016};
		logic [15:0] res[4] = '{16'h0100, 16'h0000, 16'h0100, 16'h0100};
		logic flg[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		logic c0;
		wr(autr_pkg::ADDR_SPEED, 16'h0000);
		wr(autr_pkg::ADDR_MODE, 16'h0002);
		wr(autr_pkg::ADDR_MASK, 16'h0001);
		wr(autr_pkg::ADDR_RELOAD, 16'h0100);
		for (int i = 0; i < 4; i++) begin
			wr(autr_pkg::ADDR_COUNT, 16'hFFFF);
			wr(autr_pkg::ADDR_CTRL, ctl[i]);
			ticks = 0;
			c0 = cko;
			i_pins.pulse(1);
			chk({31'h0, cko}, {31'h0, ~c0});
			rdchk(autr_pkg::ADDR_COUNT, res[i]);
			rdchk(autr_pkg::ADDR_STATUS, {15'h0000, flg[i]});
			chk({31'h0, irq}, {31'h0, flg[i]});
			chk(ticks, {31'h0, ~flg[i]});
			wr(autr_pkg::ADDR_STATUS, 16'h0001);
			wr(autr_pkg::ADDR_CTRL, 16'h0000);
			repeat (2) @(posedge sys_clk);
			chk({31'h0, irq}, 32'h0000_0000);
		end
	endtask

	task automatic t_updown();
		logic t0;
		wr(autr_pkg::ADDR_MODE, 16'h0001);
		wr(autr_pkg::ADDR_RELOAD, 16'h0010);
		wr(autr_pkg::ADDR_COUNT, 16'h0011);
		wr(autr_pkg::ADDR_CTRL, 16'h0006);
		i_pins.pulse(1);
		rdchk(autr_pkg::ADDR_COUNT, 16'h0010);
		t0 = tgl;
		i_pins.pulse(1);
		rdchk(autr_pkg::ADDR_COUNT, 16'hFFFF);
		rdchk(autr_pkg::ADDR_STATUS, 16'h0001);
		chk({31'h0, tgl}, {31'h0, ~t0});
		wr(autr_pkg::ADDR_STATUS, 16'h0001);
		i_pins.set_dir(1'b1);
		i_pins.pulse(1);
		rdchk(autr_pkg::ADDR_COUNT, 16'h0010);
		chk({31'h0, tgl}, {31'h0, t0});
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		bad_count = 0;
		checked = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_rate(1'b0, 16'h0014);
		t_rate(1'b1, 16'h0028);
		t_modes();
		t_updown();
		results();
	end
endmodule // aux_timer_updown_reload_tb
